// *** design/soa_amp_ctrl.v ***
// digital control model of the programmable output amplifier
// Contract
// RULE1 - sel high takes external pin, else array
// RULE2 - four-bit gain code, lsb bit zero
// RULE3 - unity mode overrides the gain code
// RULE4 - slow pulses step offset, converge ~100; code steps 1/128 of the gap, ~128 pulse constant
// RULE5 - controller presents zero reference at fall
// RULE6 - slow high: dac/out; low: cap/in-
// RULE7 - fast calibration only with unity high; dac_to_cap_out follows calib_fast_in with unity low too
// RULE8 - controller holds zero reference during fast
// RULE9 - fast high connects dac to capacitor
// RULE10 - four-bit offset code spans low..high reference
// RULE11 - fast calibration once per frame
// RULE12 - one slow pulse per row blanking
// RULE13 - input and code stable around calibration
// RULE14 - controller holds control pins static
`timescale 1ns/100ps
`default_nettype none
`include "soa_defs.vh"
module soa_amp_ctrl #(
	parameter integer SLOW_PULSES = `SOA_SLOW_PULSES
) (
	input  wire       clk_sys_in,
	input  wire       rst_b_in,
	input  wire       ce_in,
	input  wire       sel_extin_in,
	input  wire       amp_gain_code_b0_in,
	input  wire       amp_gain_code_b1_in,
	input  wire       amp_gain_code_b2_in,
	input  wire       amp_gain_code_b3_in,
	input  wire       unity_mode_in,
	input  wire       calib_slow_in,
	input  wire       calib_fast_in,
	input  wire       offset_code_b0_in,
	input  wire       offset_code_b1_in,
	input  wire       offset_code_b2_in,
	input  wire       offset_code_b3_in,
	output reg        src_ext_out,
	output reg  [3:0] gain_code_out,
	output reg        unity_out,
	output reg        st2_to_dac_out,
	output reg        st2_to_cap_out,
	output reg        dac_to_cap_out,
	output reg  [3:0] offset_level_out,
	output reg        calib_done_out
);
	// pins are asynchronous to clk_sys_in: two flops each before use
	localparam integer NP    = 12;
	localparam integer ACC_W = `SOA_ACC_W;

	wire [NP-1:0]    pins;
	wire [NP-1:0]    sync2;
	wire             s_sel;
	wire [3:0]       s_gain;
	wire             s_unity;
	wire             s_slow;
	wire             s_fast;
	wire [3:0]       s_code;
	wire [ACC_W-1:0] target;
	wire             slow_fall;
	wire             fast_on;
	wire             fast_rise;
	reg              slow_q;
	reg              fast_q;
	reg  [ACC_W-1:0] acc;
	reg  [ACC_W-1:0] next_acc;

	assign pins = {offset_code_b3_in, offset_code_b2_in, offset_code_b1_in,
		offset_code_b0_in, calib_fast_in, calib_slow_in, unity_mode_in,
		amp_gain_code_b3_in, amp_gain_code_b2_in, amp_gain_code_b1_in,
		amp_gain_code_b0_in, sel_extin_in};

	// one synchroniser per pin; only the second flop is read downstream
	genvar i;
	generate
		for (i = 0; i < NP; i = i + 1) begin : g_sync
			reg meta;
			reg stable;
			always @(posedge clk_sys_in) begin
				if (!rst_b_in) begin
					meta   <= 1'b0;
					stable <= 1'b0;
				end else if (ce_in) begin
					meta   <= pins[i];
					stable <= meta;
				end
			end
			assign sync2[i] = stable;
		end
	endgenerate

	// bit b0 is the lsb of both four-bit codes
	function [3:0] pack4;
		input b0;
		input b1;
		input b2;
		input b3;
		begin
			pack4 = {b3, b2, b1, b0};
		end
	endfunction

	assign s_sel     = sync2[0];
	assign s_gain    = pack4(sync2[1], sync2[2], sync2[3], sync2[4]); // RULE2
	assign s_unity   = sync2[5];
	assign s_slow    = sync2[6];
	assign s_fast    = sync2[7];
	assign s_code    = pack4(sync2[8], sync2[9], sync2[10], sync2[11]); // RULE10
	assign target    = {s_code, {(ACC_W-4){1'b0}}};
	assign slow_fall = slow_q & ~s_slow;
	assign fast_on   = s_fast & s_unity; // RULE7
	assign fast_rise = fast_on & ~fast_q;

	// first-order step toward target: 1/128 of the gap per pulse, ~128 pulse constant
	// a minimum step of one lsb keeps the last bits from stalling short of target
	function [`SOA_ACC_W-1:0] step_to;
		input [`SOA_ACC_W-1:0] cur;
		input [`SOA_ACC_W-1:0] tgt;
		reg   [`SOA_ACC_W-1:0] d;
		begin
			d = 12'h000;
			if (tgt > cur) begin
				d = (tgt - cur) >> `SOA_ACC_FRAC;
				step_to = cur + ((d == 12'h000) ? 12'h001 : d);
			end else if (tgt < cur) begin
				d = (cur - tgt) >> `SOA_ACC_FRAC;
				step_to = cur - ((d == 12'h000) ? 12'h001 : d);
			end else begin
				step_to = cur;
			end
		end
	endfunction

	// fast wins over a slow fall in the same cycle
	always @* begin
		next_acc = acc;
		if (fast_on) begin
			next_acc = target; // RULE7
		end else if (slow_fall) begin
			next_acc = step_to(acc, target); // RULE4
		end
	end

	// edge history of the calibration controls
	always @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			slow_q <= 1'b0;
			fast_q <= 1'b0;
		end else if (ce_in) begin
			slow_q <= s_slow;
			fast_q <= fast_on;
		end
	end

	// offset accumulator
	always @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			acc <= `SOA_RST_OFFSET;
		end else if (ce_in) begin
			acc <= next_acc; // RULE4 RULE7
		end
	end

	// input source and gain routing
	always @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			src_ext_out   <= `SOA_SRC_ARRAY;
			gain_code_out <= `SOA_RST_GAIN;
			unity_out     <= 1'b0;
		end else if (ce_in) begin
			src_ext_out   <= s_sel ? `SOA_SRC_EXT : `SOA_SRC_ARRAY; // RULE1
			gain_code_out <= s_unity ? `SOA_CODE_MIN : s_gain; // RULE2 RULE3
			unity_out     <= s_unity; // RULE3
		end
	end

	// calibration switches follow their pins level for level
	always @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st2_to_dac_out <= 1'b0;
			st2_to_cap_out <= 1'b1;
			dac_to_cap_out <= 1'b0;
		end else if (ce_in) begin
			st2_to_dac_out <= s_slow; // RULE6
			st2_to_cap_out <= ~s_slow; // RULE6
			dac_to_cap_out <= s_fast; // RULE9
		end
	end

	// offset level and step pulse; a held fast request reports one step only
	always @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			offset_level_out <= `SOA_CODE_MIN;
			calib_done_out   <= 1'b0;
		end else if (ce_in) begin
			offset_level_out <= next_acc[ACC_W-1:ACC_W-4]; // RULE10
			calib_done_out   <= fast_rise | slow_fall; // RULE4 RULE7
		end
	end

endmodule // soa_amp_ctrl
`default_nettype wire

// *** design/soa_defs.vh ***
// constants for the output amplifier control block
`ifndef SOA_DEFS_VH
`define SOA_DEFS_VH
`define SOA_CODE_W        4
`define SOA_CODE_MIN      4'h0
`define SOA_CODE_MAX      4'hF
`define SOA_SRC_ARRAY     1'b0
`define SOA_SRC_EXT       1'b1
`define SOA_ACC_W         12
`define SOA_ACC_FRAC      7
`define SOA_SLOW_PULSES   100
`define SOA_RST_GAIN      4'h0
`define SOA_RST_OFFSET    12'h000
`endif

// *** sim/soa_amp_ctrl_chk.sv ***
// assertions on the amplifier control ports
`timescale 1ns/100ps
`default_nettype none
module soa_chk (
	input wire logic       clk_sys_in,
	input wire logic       rst_b_in,
	input wire logic       sel_extin_in,
	input wire logic       unity_mode_in,
	input wire logic       calib_slow_in,
	input wire logic       calib_fast_in,
	input wire logic       amp_gain_code_b0_in,
	input wire logic       amp_gain_code_b1_in,
	input wire logic       amp_gain_code_b2_in,
	input wire logic       amp_gain_code_b3_in,
	input wire logic       src_ext_out,
	input wire logic       unity_out,
	input wire logic       st2_to_dac_out,
	input wire logic       st2_to_cap_out,
	input wire logic       dac_to_cap_out,
	input wire logic       calib_done_out,
	input wire logic [3:0] gain_code_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	chk_src_sel: assert property (src_ext_out == $past(sel_extin_in, 3)) else $error("src");
	chk_unity_gain: assert property (gain_code_out == ($past(unity_mode_in, 3) ? 4'h0 :
		$past({amp_gain_code_b3_in, amp_gain_code_b2_in, amp_gain_code_b1_in,
		amp_gain_code_b0_in}, 3))) else $error("gain");
	chk_unity_follow: assert property (unity_out == $past(unity_mode_in, 3)) else $error("unity");
	chk_slow_sw: assert property ((st2_to_dac_out == $past(calib_slow_in, 3)) &&
		(st2_to_cap_out != st2_to_dac_out)) else $error("sw");
	chk_fast_sw: assert property (dac_to_cap_out == $past(calib_fast_in, 3)) else $error("dac");
	chk_done_pulse: assert property (calib_done_out |=> !calib_done_out) else $error("done");
	chk_slow_step: assert property ($fell(st2_to_dac_out) |-> ##[0:1] calib_done_out) else $error("step");
endmodule // soa_chk
bind soa_amp_ctrl soa_chk u_chk (.*);
`default_nettype wire

// *** sim/soa_amp_ctrl_tb.sv ***
// self-checking bench for the amplifier control block
`timescale 1ns/100ps
`default_nettype none
module soa_amp_ctrl_tb;
	logic       clk_sys_in = 1'h0, rst_b_in = 1'h0, sel_extin_in, unity_mode_in, calib_slow_in;
	logic       calib_fast_in, src_ext_out, unity_out, st2_to_dac_out, st2_to_cap_out;
	logic       dac_to_cap_out, calib_done_out;
	logic [3:0] g, o, gain_code_out, offset_level_out;
	int         n_mismatch = 0, tests_run = 0, cyc = 0, n_done = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (calib_done_out === 1'b1) n_done++;
	soa_ctl u_ctl (.*);
	soa_amp_ctrl u_dut (.*, .ce_in(1'h1), .amp_gain_code_b0_in(g[0]), .amp_gain_code_b1_in(g[1]),
		.amp_gain_code_b2_in(g[2]), .amp_gain_code_b3_in(g[3]), .offset_code_b0_in(o[0]),
		.offset_code_b1_in(o[1]), .offset_code_b2_in(o[2]), .offset_code_b3_in(o[3]));
	task chk(input logic [3:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ceiling well above the roughly 1300 cycles the tests need
	always @(posedge clk_sys_in) if (++cyc == 5000) begin
		n_mismatch++;
		results();
	end
	initial begin
		repeat (16) @(posedge clk_sys_in);
		#1 rst_b_in = 1'h1;
		u_ctl.drv(2'h0, 4'hA, 4'h0, 1'h0, 1'h0);
		chk(gain_code_out, 4'hA);
		chk(src_ext_out, 4'h0);
		repeat (100) u_ctl.drv(2'h1, 4'hA, 4'hF, 1'h0, 1'h1);
		chk(offset_level_out inside {[4'h5:4'hE]}, 4'h1);
		chk(n_done == 100, 4'h1);
		chk(src_ext_out, 4'h1);
		chk(st2_to_cap_out, 4'h1);
		$display("slow test done");
		u_ctl.drv(2'h0, 4'hA, 4'hF, 1'h1, 1'h1);
		chk(gain_code_out, 4'h0);
		chk(unity_out, 4'h1);
		for (int c = 0; c < 16; c += 5) begin
			u_ctl.drv(2'h2, 4'hA, c[3:0], 1'h1, 1'h1);
			chk(offset_level_out, c[3:0]);
		end
		u_ctl.drv(2'h2, 4'hA, 4'h3, 1'h0, 1'h1);
		chk(offset_level_out, 4'hF);
		chk(n_done == 104, 4'h1);
		chk(dac_to_cap_out, 4'h0);
		$display("fast test done");
		results();
	end
endmodule // soa_amp_ctrl_tb
`default_nettype wire

// *** sim/soa_ctl.sv ***
// controller model driving the amplifier pins
`timescale 1ns/100ps
`default_nettype none
module soa_ctl (
	input wire logic       clk_sys_in,
	output var logic       sel_extin_in,
	output var logic       unity_mode_in,
	output var logic       calib_slow_in,
	output var logic       calib_fast_in,
	output var logic [3:0] g,
	output var logic [3:0] o
);
	initial {sel_extin_in, unity_mode_in, calib_slow_in, calib_fast_in, g, o} = 12'h000;
	// input and code settle before the pulse, so the sampled reference is clean
	task drv(input logic [1:0] fs, input logic [3:0] gn, c, input logic u, s);
		@(posedge clk_sys_in) #1 {g, o, unity_mode_in, sel_extin_in} = {gn, c, u, s};
		repeat (3) @(posedge clk_sys_in);
		#1 {calib_fast_in, calib_slow_in} = fs;
		repeat (4) @(posedge clk_sys_in);
		#1 {calib_fast_in, calib_slow_in} = 2'h0;
		repeat (4) @(posedge clk_sys_in);
		// let the edge's register updates settle before the caller looks
		#2;
	endtask
endmodule // soa_ctl
`default_nettype wire
